//--- pkg/spr_pkg.sv
`default_nettype none
package spr_pkg;

  // Clock rate and timing limits.
  localparam int unsigned MCLK_HZ        = 25_000_000;
  localparam int unsigned MCLK_NS        = 1_000_000_000 / MCLK_HZ;
  localparam int unsigned MIN_CLK_KHZ    = 500;
  localparam int unsigned MIN_CLK_NS     = 1_000_000 / MIN_CLK_KHZ;
  localparam int unsigned STANDBY_CYCLES = MIN_CLK_NS / MCLK_NS;
  localparam int unsigned LOCK_PERIODS   = 4;

  // Frame layout.
  localparam int unsigned FRAME_BITS   = 30;
  localparam int unsigned PAYLOAD_BITS = 27;
  localparam int unsigned PARITY_POS   = 27;
  localparam int unsigned BITS_1LANE   = 30;
  localparam int unsigned BITS_2LANE   = 15;
  localparam int unsigned BITS_3LANE   = 10;

  // Link select codes.
  localparam logic [1:0] LS_ONE   = 2'h0;
  localparam logic [1:0] LS_TWO   = 2'h1;
  localparam logic [1:0] LS_THREE = 2'h2;

  // Register offsets and reset values.
  localparam logic [3:0]  CTRL_OFS     = 4'h0;
  localparam logic [3:0]  STATUS_OFS   = 4'h4;
  localparam logic [3:0]  ERRCNT_OFS   = 4'h8;
  localparam int unsigned CTRL_EN_POS  = 0;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Operating modes, one-hot.
  typedef enum logic [3:0] {
    MODE_SHUTDOWN = 4'b0001,
    MODE_STANDBY  = 4'b0010,
    MODE_ACQUIRE  = 4'b0100,
    MODE_RECEIVE  = 4'b1000
  } spr_mode_e;

  // Deserialized payload word.
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic       vsync;
    logic       hsync;
    logic       den;
  } spr_pix_s;

  // Static pattern: colours and syncs high, data enable low.
  localparam spr_pix_s PIX_IDLE = '{red: 8'hFF, green: 8'hFF, blue: 8'hFF,
                                    vsync: 1'h1, hsync: 1'h1, den: 1'h0};

endpackage : spr_pkg
`default_nettype wire

//--- verilog/spr_receiver.sv
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module spr_receiver #(
  parameter int unsigned LOCK_PERIODS = spr_pkg::LOCK_PERIODS
) (
  // Clock and reset.
  input  wire  logic        MCLK,
  input  wire  logic        RSTN,
  // Serial link pins.
  input  wire  logic        LANE_CLK,
  input  wire  logic        CLK_CM_HIGH,
  input  wire  logic [2:0]  SERIAL_LANE,
  // Static control pins.
  input  wire  logic        RECEIVER_ENABLE_IN,
  input  wire  logic        LINK_SELECT_LO,
  input  wire  logic        LINK_SELECT_HI,
  input  wire  logic        BUS_REVERSE_SELECT,
  // Parallel output bus.
  output var   logic [23:0] PIX_DATA,
  output var   logic        VERTICAL_SYNC,
  output var   logic        HORIZONTAL_SYNC,
  output var   logic        DATA_ENABLE,
  output var   logic        PIXEL_CLOCK_OUT,
  output var   logic        PARITY_ERROR_FLAG,
  // AXI4-Lite register slave.
  input  wire  logic [3:0]  S_AXI_AWADDR,
  input  wire  logic        S_AXI_AWVALID,
  output var   logic        S_AXI_AWREADY,
  input  wire  logic [31:0] S_AXI_WDATA,
  input  wire  logic [3:0]  S_AXI_WSTRB,
  input  wire  logic        S_AXI_WVALID,
  output var   logic        S_AXI_WREADY,
  output var   logic [1:0]  S_AXI_BRESP,
  output var   logic        S_AXI_BVALID,
  input  wire  logic        S_AXI_BREADY,
  input  wire  logic [3:0]  S_AXI_ARADDR,
  input  wire  logic        S_AXI_ARVALID,
  output var   logic        S_AXI_ARREADY,
  output var   logic [31:0] S_AXI_RDATA,
  output var   logic [1:0]  S_AXI_RRESP,
  output var   logic        S_AXI_RVALID,
  input  wire  logic        S_AXI_RREADY
);

  // Bits per lane for a link select code; reserved code yields zero.
  function automatic logic [4:0] lane_bits(input logic [1:0] ls);
    if (ls == spr_pkg::LS_ONE) begin
      lane_bits = 5'(spr_pkg::BITS_1LANE);
    end else if (ls == spr_pkg::LS_TWO) begin
      lane_bits = 5'(spr_pkg::BITS_2LANE);
    end else if (ls == spr_pkg::LS_THREE) begin
      lane_bits = 5'(spr_pkg::BITS_3LANE);
    end else begin
      lane_bits = 5'h00;
    end
  endfunction : lane_bits
  // Reverses the 24 colour bits end for end.
  function automatic logic [23:0] rev24(input logic [23:0] v);
    for (int i = 0; i < 24; i++) begin
      rev24[i] = v[23 - i];
    end
  endfunction : rev24
  localparam logic [7:0] STBY_CNT = 8'(spr_pkg::STANDBY_CYCLES);

  logic                clk_s1_reg;
  logic                clk_s2_reg;
  logic                clk_s3_reg;
  logic [2:0]          lane_s1_reg;
  logic [2:0]          lane_s2_reg;
  logic [3:0]          ctl_s1_reg;
  logic [3:0]          ctl_s2_reg;
  logic [29:0]         sr0_reg;
  logic [29:0]         sr1_reg;
  logic [29:0]         sr2_reg;
  logic [7:0]          per_cnt_reg;
  logic [3:0]          lock_cnt_reg;
  logic [4:0]          phase_reg;
  logic [15:0]         err_cnt_reg;
  logic                soft_en_reg;
  spr_pkg::spr_mode_e  mode_reg;
  spr_pkg::spr_mode_e  mode_next;
  spr_pkg::spr_pix_s   pix_reg;
  logic [29:0]         frame;
  logic [4:0]          fbits;
  logic                edge_seen;
  logic                per_match;
  logic                clk_absent;
  logic                enabled;
  logic                cm_high;
  logic [1:0]          ls;
  logic                frame_done;
  logic                par_bad;
  logic                err_event;

  // Two-flop synchronisers for every pin from outside the clock domain except BUS_REVERSE_SELECT.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      clk_s1_reg  <= 1'h0;
      clk_s2_reg  <= 1'h0;
      clk_s3_reg  <= 1'h0;
      lane_s1_reg <= 3'h0;
      lane_s2_reg <= 3'h0;
      ctl_s1_reg  <= 4'h0;
      ctl_s2_reg  <= 4'h0;
    end else begin
      clk_s1_reg  <= LANE_CLK;
      clk_s2_reg  <= clk_s1_reg;
      clk_s3_reg  <= clk_s2_reg;
      lane_s1_reg <= SERIAL_LANE;
      lane_s2_reg <= lane_s1_reg;
      ctl_s1_reg  <= {RECEIVER_ENABLE_IN, CLK_CM_HIGH, LINK_SELECT_HI, LINK_SELECT_LO};
      ctl_s2_reg  <= ctl_s1_reg;
    end
  end
  // Synchronised control levels and lane clock edge.
  assign enabled    = ctl_s2_reg[3] & soft_en_reg;
  assign cm_high    = ctl_s2_reg[2];
  assign ls         = ctl_s2_reg[1:0];
  assign fbits      = lane_bits(ls);
  assign edge_seen  = clk_s2_reg & ~clk_s3_reg;
  assign per_match  = (fbits != 5'h00) && (per_cnt_reg == {3'h0, fbits});
  assign clk_absent = per_cnt_reg >= STBY_CNT;
  // Cycles since the last lane clock edge, saturating.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      per_cnt_reg <= 8'hFF;
    end else if (edge_seen) begin
      per_cnt_reg <= 8'h01;
    end else if (per_cnt_reg != 8'hFF) begin
      per_cnt_reg <= per_cnt_reg + 8'h01;
    end
  end
  // Lock detector: consecutive lane clock periods of one frame length each.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      lock_cnt_reg <= 4'h0;
    end else if (mode_reg != spr_pkg::MODE_ACQUIRE) begin
      lock_cnt_reg <= 4'h0;
    end else if (edge_seen) begin
      lock_cnt_reg <= per_match ? lock_cnt_reg + 4'h1 : 4'h0;
    end
  end
  // Operating mode selection.
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      spr_pkg::MODE_SHUTDOWN: begin
        if (enabled) begin
          mode_next = spr_pkg::MODE_STANDBY;
        end
      end
      spr_pkg::MODE_STANDBY: begin
        if (edge_seen && !cm_high && fbits != 5'h00) begin
          mode_next = spr_pkg::MODE_ACQUIRE;
        end
      end
      spr_pkg::MODE_ACQUIRE: begin
        if (lock_cnt_reg == 4'(LOCK_PERIODS)) begin
          mode_next = spr_pkg::MODE_RECEIVE;
        end
      end
      spr_pkg::MODE_RECEIVE: begin
        if (edge_seen && !per_match) begin
          mode_next = spr_pkg::MODE_ACQUIRE;
        end
      end
      default: begin
        mode_next = spr_pkg::MODE_SHUTDOWN;
      end
    endcase
    if (mode_reg != spr_pkg::MODE_SHUTDOWN && (cm_high || clk_absent || fbits == 5'h00)) begin
      mode_next = spr_pkg::MODE_STANDBY;
    end
    if (!enabled) begin
      mode_next = spr_pkg::MODE_SHUTDOWN;
    end
  end
  // Mode register.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_reg <= spr_pkg::MODE_SHUTDOWN;
    end else begin
      mode_reg <= mode_next;
    end
  end
  // Lane shifters; lanes are ignored outside acquire and receive.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      sr0_reg <= 30'h0000_0000;
      sr1_reg <= 30'h0000_0000;
      sr2_reg <= 30'h0000_0000;
    end else if (mode_reg == spr_pkg::MODE_ACQUIRE || mode_reg == spr_pkg::MODE_RECEIVE) begin
      sr0_reg <= {sr0_reg[28:0], lane_s2_reg[0]};
      sr1_reg <= {sr1_reg[28:0], lane_s2_reg[1]};
      sr2_reg <= {sr2_reg[28:0], lane_s2_reg[2]};
    end
  end
  // Frame assembly, lane 0 low; the last bit still stands in the lane synchroniser.
  always_comb begin
    if (ls == spr_pkg::LS_TWO) begin
      frame = {sr1_reg[13:0], lane_s2_reg[1], sr0_reg[13:0], lane_s2_reg[0]};
    end else if (ls == spr_pkg::LS_THREE) begin
      frame = {sr2_reg[8:0], lane_s2_reg[2], sr1_reg[8:0], lane_s2_reg[1], sr0_reg[8:0], lane_s2_reg[0]};
    end else begin
      frame = {sr0_reg[28:0], lane_s2_reg[0]};
    end
  end
  // A frame completes at each lane clock edge that ends a full-length period while receiving.
  assign frame_done = edge_seen && mode_reg == spr_pkg::MODE_RECEIVE && per_match;
  assign par_bad    = ~^frame[spr_pkg::PARITY_POS:0];
  assign err_event  = frame_done && par_bad;
  // Output word: bad words are dropped and the last good one held.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      pix_reg <= spr_pkg::PIX_IDLE;
    end else if (mode_reg != spr_pkg::MODE_RECEIVE) begin
      pix_reg <= spr_pkg::PIX_IDLE;
    end else if (frame_done && !par_bad) begin
      pix_reg <= spr_pkg::spr_pix_s'(frame[spr_pkg::PAYLOAD_BITS-1:0]);
    end
  end
  // Pins follow the word, colour order set by the reverse select.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      PIX_DATA        <= 24'hFFFFFF;
      VERTICAL_SYNC   <= 1'h1;
      HORIZONTAL_SYNC <= 1'h1;
      DATA_ENABLE     <= 1'h0;
    end else begin
      PIX_DATA        <= BUS_REVERSE_SELECT ? rev24({pix_reg.red, pix_reg.green, pix_reg.blue})
                                            : {pix_reg.red, pix_reg.green, pix_reg.blue};
      VERTICAL_SYNC   <= pix_reg.vsync;
      HORIZONTAL_SYNC <= pix_reg.hsync;
      DATA_ENABLE     <= pix_reg.den;
    end
  end
  // Phase within the pixel period; the flag and clock move with it.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      phase_reg <= 5'h00;
    end else if (frame_done) begin
      phase_reg <= 5'h00;
    end else if (phase_reg != 5'h1F) begin
      phase_reg <= phase_reg + 5'h01;
    end
  end
  // Recovered clock: low for the first half period, high for the second.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      PIXEL_CLOCK_OUT <= 1'h0;
    end else if (mode_reg != spr_pkg::MODE_RECEIVE || frame_done) begin
      PIXEL_CLOCK_OUT <= 1'h0;
    end else if (phase_reg == (fbits >> 1) - 5'h01) begin
      PIXEL_CLOCK_OUT <= 1'h1;
    end
  end

  // Error flag rises with the recovered clock fall and falls half a period later.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      PARITY_ERROR_FLAG <= 1'h0;
    end else if (err_event) begin
      PARITY_ERROR_FLAG <= 1'h1;
    end else if (phase_reg == (fbits >> 1) - 5'h01 || mode_reg != spr_pkg::MODE_RECEIVE) begin
      PARITY_ERROR_FLAG <= 1'h0;
    end
  end

  // AXI4-Lite write path: address and data taken in either order.
  logic       aw_have_reg;
  logic       w_have_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic       wr_fire;
  logic       err_clr;
  assign wr_fire = aw_have_reg && w_have_reg && !S_AXI_BVALID;
  assign err_clr = wr_fire && aw_addr_reg == spr_pkg::ERRCNT_OFS;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_have_reg   <= 1'h0;
      w_have_reg    <= 1'h0;
      aw_addr_reg   <= 4'h0;
      w_data_reg    <= 32'h0000_0000;
      S_AXI_AWREADY <= 1'h0;
      S_AXI_WREADY  <= 1'h0;
      S_AXI_BVALID  <= 1'h0;
      S_AXI_BRESP   <= 2'h0;
    end else begin
      S_AXI_AWREADY <= !aw_have_reg && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !w_have_reg && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_reg <= 1'h1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_reg <= 1'h1;
        w_data_reg <= S_AXI_WDATA;
      end
      if (wr_fire) begin
        aw_have_reg  <= 1'h0;
        w_have_reg   <= 1'h0;
        S_AXI_BVALID <= 1'h1;
        if (aw_addr_reg == spr_pkg::CTRL_OFS || aw_addr_reg == spr_pkg::ERRCNT_OFS ||
            aw_addr_reg == spr_pkg::STATUS_OFS) begin
          S_AXI_BRESP <= spr_pkg::RESP_OKAY;
        end else begin
          S_AXI_BRESP <= spr_pkg::RESP_SLVERR;
        end
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'h0;
      end
    end
  end

  // Control register: soft enable, honoured with the lowest strobe.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      soft_en_reg <= spr_pkg::CTRL_RESET[spr_pkg::CTRL_EN_POS];
    end else if (wr_fire && aw_addr_reg == spr_pkg::CTRL_OFS && S_AXI_WSTRB[0]) begin
      soft_en_reg <= w_data_reg[spr_pkg::CTRL_EN_POS];
    end
  end

  // Parity error counter; a write clears it, a same-cycle error still counts.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      err_cnt_reg <= 16'h0000;
    end else if (err_clr) begin
      err_cnt_reg <= {15'h0000, err_event};
    end else if (err_event && err_cnt_reg != 16'hFFFF) begin
      err_cnt_reg <= err_cnt_reg + 16'h0001;
    end
  end

  // AXI4-Lite read path, one read at a time.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      S_AXI_ARREADY <= 1'h0;
      S_AXI_RVALID  <= 1'h0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= 2'h0;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'h1;
        S_AXI_RRESP  <= spr_pkg::RESP_OKAY;
        if (S_AXI_ARADDR == spr_pkg::CTRL_OFS) begin
          S_AXI_RDATA <= {31'h0000_0000, soft_en_reg};
        end else if (S_AXI_ARADDR == spr_pkg::STATUS_OFS) begin
          S_AXI_RDATA <= {26'h000_0000, ls, mode_reg};
        end else if (S_AXI_ARADDR == spr_pkg::ERRCNT_OFS) begin
          S_AXI_RDATA <= {16'h0000, err_cnt_reg};
        end else begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= spr_pkg::RESP_SLVERR;
        end
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'h0;
      end
    end
  end

  // Checks on mode, static pattern, parity flag and output timing.
  parity_late_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    mode_reg != spr_pkg::MODE_RECEIVE |=> !$rose(PARITY_ERROR_FLAG))
    else $error("parity flag rose outside receive");
  flag_pulse_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    err_event && ls == spr_pkg::LS_THREE |=> PARITY_ERROR_FLAG [*5] ##1 !PARITY_ERROR_FLAG)
    else $error("parity flag width wrong in three-lane mode");
  flag_cause_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    $rose(PARITY_ERROR_FLAG) |-> $past(frame_done) && $past(par_bad))
    else $error("parity flag without even-parity frame");
  shut_entry_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    !enabled |=> mode_reg == spr_pkg::MODE_SHUTDOWN)
    else $error("no shutdown after enable low");
  static_out_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    mode_reg != spr_pkg::MODE_RECEIVE [*3] |-> PIX_DATA == 24'hFFFFFF && VERTICAL_SYNC &&
      HORIZONTAL_SYNC && !DATA_ENABLE && !PIXEL_CLOCK_OUT)
    else $error("static pattern not held");
  standby_cm_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    enabled && cm_high |=> mode_reg == spr_pkg::MODE_STANDBY)
    else $error("no standby on high common mode");
  standby_slow_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    enabled && clk_absent |=> mode_reg == spr_pkg::MODE_STANDBY)
    else $error("no standby on slow clock");
  lock_entry_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    $rose(mode_reg == spr_pkg::MODE_RECEIVE) |-> $past(lock_cnt_reg) == 4'(LOCK_PERIODS))
    else $error("receive entered without lock");
  bad_hold_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    mode_reg == spr_pkg::MODE_RECEIVE && err_event |=> $stable(pix_reg))
    else $error("bad word reached output");
  clk_high_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    frame_done && ls == spr_pkg::LS_TWO && mode_next == spr_pkg::MODE_RECEIVE |=>
      !PIXEL_CLOCK_OUT [*7] ##1 PIXEL_CLOCK_OUT)
    else $error("recovered clock phase wrong in two-lane mode");

endmodule : spr_receiver
`default_nettype wire

//--- tb/spr_tx_model.sv
`timescale 1ns/1ns
`default_nettype none
module spr_tx_model (
  // Clock and frame source.
  input  wire logic        mclk,
  input  wire logic        run,
  input  wire logic [1:0]  sel,
  input  wire logic [29:0] frame,
  // Link pins and frame request.
  output var  logic        lane_clk,
  output var  logic [2:0]  lanes,
  output var  logic        need
);
  int          n;
  int          k    = 0;
  logic [29:0] cur  = '0;
  logic [2:0]  last = '0;

  // Bits per lane follow the lane count; the reserved code sends a one-lane frame.
  assign n = (sel == 2'h1) ? 15 : (sel == 2'h2) ? 10 : 30;

  // After the first, the period is exactly n bit times, so the lane clock never runs slow.
  always @(posedge mclk) begin
    k    <= (!run || k == n - 1) ? 0 : k + 1;
    last <= lanes;
    if (!run || k == n - 1)
      cur <= frame;
  end

  // Each lane sends its slice most significant bit first; an unused lane toggles.
  always_comb begin
    for (int l = 0; l < 3; l++)
      lanes[l] = (run && l * n < 30) ? cur[l * n + n - 1 - k] : ~last[l];
  end

  // The forwarded clock rises with the last bit of a frame and stands low while idle.
  assign lane_clk = run && (k == n - 1 || k + 1 < n / 2);
  assign need     = run && k == n - 2;
endmodule : spr_tx_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [26:0] IDLE = 27'h7FFFFFE;
  localparam logic [26:0] P    = 27'h5A3C96B;
  localparam logic [26:0] Q    = 27'h1E69F25;

  logic        mclk = 1'b0, rstn = 1'b0, cm = 1'b1, en = 1'b1, rev = 1'b0, run = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [1:0]  sel = 2'h0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [29:0] frame = 30'h0;
  logic [23:0] pix;
  logic [31:0] rdata, d;
  logic [2:0]  lanes;
  logic [1:0]  bresp, rresp;
  logic        lclk, need, vs, hs, de, pclk, perr, awready, wready, bvalid, arready, rvalid;
  int          miscompares = 0, n_checks = 0, cycles = 0, hi, lo, nb;
  wire  [26:0] pins = {pix, vs, hs, de};

  assign nb = (sel == 2'h1) ? 15 : (sel == 2'h2) ? 10 : 30;

  // Lock count shortened so that each lane mode locks after two matching periods.
  spr_receiver #(.LOCK_PERIODS(2)) u_dut (
    .MCLK(mclk), .RSTN(rstn), .LANE_CLK(lclk), .CLK_CM_HIGH(cm), .SERIAL_LANE(lanes),
    .RECEIVER_ENABLE_IN(en), .LINK_SELECT_LO(sel[0]), .LINK_SELECT_HI(sel[1]), .BUS_REVERSE_SELECT(rev),
    .PIX_DATA(pix), .VERTICAL_SYNC(vs), .HORIZONTAL_SYNC(hs), .DATA_ENABLE(de), .PIXEL_CLOCK_OUT(pclk),
    .PARITY_ERROR_FLAG(perr), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1));

  spr_tx_model u_tx (.mclk(mclk), .run(run), .sel(sel), .frame(frame), .lane_clk(lclk), .lanes(lanes),
    .need(need));

  // Free-running system clock.
  initial begin
    forever #20 mclk = ~mclk;
  end

  // A hung handshake ends the run as a failure.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Write: address and data offered together, each released when taken.
  task automatic axw(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    logic done;
    done    = 1'b0;
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      done = bvalid;
    end
    chk(bresp, er);
  endtask : axw

  // Read: the data land in d at the edge that carries the answer.
  task automatic rd(input logic [3:0] a, input logic [1:0] er);
    logic done;
    done    = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (arready)
        arvalid <= 1'b0;
      done = rvalid;
    end
    d = rdata;
    chk(rresp, er);
  endtask : rd

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    rd(a, spr_pkg::RESP_OKAY);
    chk(d, exp);
  endtask : rdc

  function automatic logic [31:0] st(input logic [3:0] m);
    return {26'h0, sel, m};
  endfunction : st

  // Frame with reserved bits set and an odd or deliberately even parity bit.
  function automatic logic [29:0] mk(input logic [26:0] p, input logic bad);
    return {2'h3, ~^p ^ bad, p};
  endfunction : mk

  function automatic logic [26:0] ex(input logic [26:0] p);
    ex = p;
    for (int i = 0; i < 24; i++)
      ex[3 + i] = p[26 - i];
  endfunction : ex

  // Queue one frame, then count flag and low clock cycles around its boundary.
  task automatic xfer(input logic [29:0] f);
    hi = 0;
    lo = 0;
    @(posedge mclk iff need);
    frame <= f;
    @(posedge mclk iff need);
    @(posedge mclk);
    repeat (nb / 2 + 6) begin
      @(posedge mclk);
      hi += (perr === 1'b1);
      lo += (pclk === 1'b0);
    end
  endtask : xfer

  // Main sequence: registers, power modes, then every lane mode in turn.
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rdc(spr_pkg::CTRL_OFS, spr_pkg::CTRL_RESET);
    rd(4'hC, spr_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    run <= 1'b1;
    repeat (20) @(posedge mclk);
    rdc(spr_pkg::STATUS_OFS, st(4'h2));
    chk(pins, IDLE);
    en <= 1'b0;
    repeat (8) @(posedge mclk);
    rdc(spr_pkg::STATUS_OFS, st(4'h1));
    chk(pins, IDLE);
    en <= 1'b1;
    axw(spr_pkg::STATUS_OFS, 32'h0, spr_pkg::RESP_OKAY);
    axw(spr_pkg::CTRL_OFS, 32'h0, spr_pkg::RESP_OKAY);
    repeat (8) @(posedge mclk);
    rdc(spr_pkg::STATUS_OFS, st(4'h1));
    axw(spr_pkg::CTRL_OFS, 32'h1, spr_pkg::RESP_OKAY);
    cm <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      run <= 1'b0;
      sel <= s[1:0];
      rev <= 1'b0;
      repeat (70) @(posedge mclk);
      rdc(spr_pkg::STATUS_OFS, st(4'h2));
      run <= 1'b1;
      if (s == 3) begin
        repeat (100) @(posedge mclk);
        rdc(spr_pkg::STATUS_OFS, st(4'h2));
      end else begin
        xfer(mk(P, 1'b1));
        chk(pins, IDLE);
        chk(hi, 0);
        chk(lo, nb / 2 + 6);
        repeat (2) xfer(mk(P, 1'b0));
        chk(pins, P);
        chk(lo, nb / 2);
        rdc(spr_pkg::STATUS_OFS, st(4'h8));
        xfer(mk(Q, 1'b1));
        chk(pins, P);
        chk(hi, nb / 2);
        rev <= 1'b1;
        xfer(mk(Q, 1'b0));
        chk(pins, ex(Q));
      end
    end
    rd(spr_pkg::ERRCNT_OFS, spr_pkg::RESP_OKAY);
    chk(d != 32'h0, 32'h1);
    axw(spr_pkg::ERRCNT_OFS, 32'h0, spr_pkg::RESP_OKAY);
    rdc(spr_pkg::ERRCNT_OFS, 32'h0);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
